// ==== verilog/bps_sequencer.sv ====
// blind push-button sequencer: edges in, STEP/MOVE telegrams out
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module bps_sequencer #(
   parameter int TICK_CYCLES = bps_pkg::TICK_CYCLES
) (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   input  wire logic                          btn,
   input  wire logic [bps_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic [bps_pkg::DATA_W-1:0]    reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [bps_pkg::DATA_W-1:0]    reg_rdata,
   output bps_pkg::bps_tg_s                   tg
);

   // ticks for a base code (power of two of 130 ms) times a factor
   function automatic logic [15:0] calc_ticks(input logic [3:0] base, input logic [6:0] fact);
      calc_ticks = 16'({9'h000, fact} << base);
   endfunction

   // clamp of written base and factor to legal range
   function automatic logic [3:0] clamp_base(input logic [3:0] b);
      clamp_base = (b > bps_pkg::BASE_MAX) ? bps_pkg::BASE_MAX : b;
   endfunction

   function automatic logic [6:0] clamp_fact(input logic [6:0] f, input logic [6:0] fmin);
      clamp_fact = (f < fmin) ? fmin : f;
   endfunction

   logic                 btn_meta;
   logic                 btn_sync;
   logic                 btn_prev;
   logic                 rise;
   logic                 fall;
   bps_pkg::bps_mode_e   mode;
   logic                 concept;
   logic [3:0]           long_base;
   logic [6:0]           long_fact;
   logic [3:0]           slat_base;
   logic [6:0]           slat_fact;
   bps_pkg::bps_state_e  state;
   bps_pkg::bps_state_e  next_state;
   logic                 last_dir;
   logic                 next_last_dir;
   logic [31:0]          presc;
   logic                 tick;
   logic [15:0]          remain;
   logic                 expire;
   logic                 load_long;
   logic                 load_slat;
   logic                 send;
   logic                 send_move;
   logic                 send_down;
   logic [15:0]          tg_count;
   logic                 wr_cfg;
   logic                 wr_ltime;
   logic                 wr_stime;

   // button synchroniser and edge detect
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         btn_meta <= 1'b0;
         btn_sync <= 1'b0;
         btn_prev <= 1'b0;
      end else begin
         btn_meta <= btn;
         btn_sync <= btn_meta;
         btn_prev <= btn_sync;
      end
   end

   assign rise = btn_sync & ~btn_prev;
   assign fall = ~btn_sync & btn_prev;

   // register write decode
   always_comb begin
      wr_cfg   = 1'b0;
      wr_ltime = 1'b0;
      wr_stime = 1'b0;
      if (reg_wr && reg_addr == bps_pkg::OFS_CFG) begin
         wr_cfg = 1'b1;
      end else if (reg_wr && reg_addr == bps_pkg::OFS_LTIME) begin
         wr_ltime = 1'b1;
      end else if (reg_wr && reg_addr == bps_pkg::OFS_STIME) begin
         wr_stime = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode    <= bps_pkg::MODE_RST;
         concept <= bps_pkg::CONCEPT_SLS;
      end else if (wr_cfg) begin
         mode    <= bps_pkg::bps_mode_e'(reg_wdata[bps_pkg::CFG_MODE_LSB +: 2]);
         concept <= reg_wdata[bps_pkg::CFG_CONCEPT];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         long_base <= bps_pkg::LONG_BASE_RST;
         long_fact <= bps_pkg::LONG_FACT_RST;
      end else if (wr_ltime) begin
         long_base <= clamp_base(reg_wdata[bps_pkg::TIME_BASE_LSB +: 4]);
         long_fact <= clamp_fact(reg_wdata[bps_pkg::TIME_FACT_LSB +: 7], bps_pkg::LONG_FACT_MIN);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         slat_base <= bps_pkg::SLAT_BASE_RST;
         slat_fact <= bps_pkg::SLAT_FACT_RST;
      end else if (wr_stime) begin
         slat_base <= clamp_base(reg_wdata[bps_pkg::TIME_BASE_LSB +: 4]);
         slat_fact <= clamp_fact(reg_wdata[bps_pkg::TIME_FACT_LSB +: 7], bps_pkg::SLAT_FACT_MIN);
      end
   end

   // 130 ms timebase, restarted with each timer load
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         presc <= 32'h0;
      end else if (load_long || load_slat || presc == 32'(TICK_CYCLES - 1)) begin
         presc <= 32'h0;
      end else begin
         presc <= presc + 32'h1;
      end
   end

   assign tick   = (presc == 32'(TICK_CYCLES - 1));
   assign expire = tick && remain == 16'h0001 && state != bps_pkg::ST_IDLE;

   // shared timer for long-actuation and slat-window periods
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         remain <= 16'h0000;
      end else if (load_long) begin
         remain <= calc_ticks(long_base, long_fact);
      end else if (load_slat) begin
         remain <= calc_ticks(slat_base, slat_fact);
      end else if (tick && remain != 16'h0000) begin
         remain <= remain - 16'h0001;
      end
   end

   // sequence control
   always_comb begin
      next_state    = state;
      next_last_dir = last_dir;
      load_long     = 1'b0;
      load_slat     = 1'b0;
      send          = 1'b0;
      send_move     = 1'b0;
      send_down     = 1'b0;
      if (mode == bps_pkg::MODE_NONE) begin
         next_state = bps_pkg::ST_IDLE;
      end else if (rise) begin
         if (concept == bps_pkg::CONCEPT_SLS) begin
            send       = 1'b1;
            load_long  = 1'b1;
            next_state = bps_pkg::ST_LONG;
         end else begin
            send       = 1'b1;
            send_move  = 1'b1;
            load_slat  = 1'b1;
            next_state = bps_pkg::ST_SLAT;
         end
      end else begin
         case (state)
            bps_pkg::ST_LONG: begin
               if (fall) begin
                  next_state = bps_pkg::ST_IDLE;
               end else if (expire) begin
                  send       = 1'b1;
                  send_move  = 1'b1;
                  load_slat  = 1'b1;
                  next_state = bps_pkg::ST_SLAT;
               end
            end
            bps_pkg::ST_SLAT: begin
               if (fall) begin
                  send       = 1'b1;
                  next_state = bps_pkg::ST_IDLE;
               end else if (expire) begin
                  next_state = bps_pkg::ST_IDLE;
               end
            end
            default: begin
               next_state = bps_pkg::ST_IDLE;
            end
         endcase
      end
      // direction of the telegram
      case (mode)
         bps_pkg::MODE_UP: begin
            send_down = 1'b0;
         end
         bps_pkg::MODE_DOWN: begin
            send_down = 1'b1;
         end
         bps_pkg::MODE_TOGGLE: begin
            if (send && send_move) begin
               next_last_dir = ~last_dir;
               send_down     = ~last_dir;
            end else begin
               send_down = ~last_dir;
            end
         end
         default: begin
            send_down = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= bps_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         last_dir <= bps_pkg::DIR_RST;
      end else begin
         last_dir <= next_last_dir;
      end
   end

   // telegram output, one-cycle pulse
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tg <= '0;
      end else begin
         tg.valid <= send;
         tg.move  <= send ? send_move : 1'b0;
         tg.down  <= send ? send_down : 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tg_count <= 16'h0000;
      end else if (send) begin
         tg_count <= tg_count + 16'h0001;
      end
   end

   // register read, data one cycle after strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_addr == bps_pkg::OFS_CFG) begin
         reg_rdata <= {27'h0, concept, 2'h0, 2'(mode)};
      end else if (reg_addr == bps_pkg::OFS_LTIME) begin
         reg_rdata <= {17'h0, long_fact, 4'h0, long_base};
      end else if (reg_addr == bps_pkg::OFS_STIME) begin
         reg_rdata <= {17'h0, slat_fact, 4'h0, slat_base};
      end else if (reg_addr == bps_pkg::OFS_STATUS) begin
         reg_rdata <= {27'h0, btn_sync, last_dir, 3'(state)};
      end else if (reg_addr == bps_pkg::OFS_TGCNT) begin
         reg_rdata <= {16'h0, tg_count};
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule // bps_sequencer

// ==== verilog/bps_pkg.sv ====
// package of constants and types for the blind push-button sequencer
package bps_pkg;

   localparam int CLK_HZ        = 100_000_000;
   localparam int TICK_TIME_MS  = 130;
   localparam int TICK_CYCLES   = TICK_TIME_MS * (CLK_HZ / 1000);

   localparam int ADDR_W        = 8;
   localparam int DATA_W        = 32;

   localparam logic [7:0] OFS_CFG    = 8'h00;
   localparam logic [7:0] OFS_LTIME  = 8'h04;
   localparam logic [7:0] OFS_STIME  = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_TGCNT  = 8'h10;

   localparam int CFG_MODE_LSB   = 0;
   localparam int CFG_CONCEPT    = 4;
   localparam int TIME_BASE_LSB  = 0;
   localparam int TIME_FACT_LSB  = 8;
   localparam int ST_STATE_LSB   = 0;
   localparam int ST_DIR         = 3;
   localparam int ST_BTN         = 4;

   localparam logic [3:0] BASE_MAX     = 4'h8;
   localparam logic [6:0] FACT_MAX     = 7'h7F;
   localparam logic [6:0] LONG_FACT_MIN = 7'h04;
   localparam logic [6:0] SLAT_FACT_MIN = 7'h03;

   localparam logic [3:0] LONG_BASE_RST = 4'h0;
   localparam logic [6:0] LONG_FACT_RST = 7'h04;
   localparam logic [3:0] SLAT_BASE_RST = 4'h0;
   localparam logic [6:0] SLAT_FACT_RST = 7'h14;

   typedef enum logic [1:0] {
      MODE_NONE   = 2'h0,
      MODE_UP     = 2'h1,
      MODE_DOWN   = 2'h2,
      MODE_TOGGLE = 2'h3
   } bps_mode_e;

   localparam bps_mode_e MODE_RST    = MODE_UP;
   localparam logic      CONCEPT_SLS = 1'b0;
   localparam logic      CONCEPT_LS  = 1'b1;
   localparam logic      DIR_RST     = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LONG = 3'b010,
      ST_SLAT = 3'b100
   } bps_state_e;

   typedef struct packed {
      logic valid;
      logic move;
      logic down;
   } bps_tg_s;

endpackage

// ==== bench/bps_sequencer_asserts.sv ====
// port checker for the blind push-button sequencer
`timescale 1ns/100ps
module bps_sequencer_asserts #(
   parameter int TICK_CYCLES = bps_pkg::TICK_CYCLES
) (
   input wire logic                       ref_clk,
   input wire logic                       rst,
   input wire logic                       btn,
   input wire logic [bps_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [bps_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                       reg_wr,
   input wire logic                       reg_rd,
   input wire logic [bps_pkg::DATA_W-1:0] reg_rdata,
   input wire bps_pkg::bps_tg_s           tg
);
   logic [1:0] mode_q;
   logic       ls_q;
   logic       mv_dn;
   // shadow of mode and concept
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_q <= 2'h1;
         ls_q   <= 1'b0;
      end else if (reg_wr && reg_addr == bps_pkg::OFS_CFG) begin
         mode_q <= reg_wdata[1:0];
         ls_q   <= reg_wdata[4];
      end
   end
   // direction of last toggle MOVE
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) mv_dn <= 1'b1;
      else if (tg.valid && tg.move && mode_q == 2'h3) mv_dn <= tg.down;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   AST_PULSE: assert property (tg.valid |=> !tg.valid)
      else $error("telegram pulse too long");
   AST_QUIET: assert property (!tg.valid |-> !tg.move && !tg.down)
      else $error("telegram fields without valid");
   AST_NONE: assert property ($past(mode_q) == 2'h0 && mode_q == 2'h0 |-> !tg.valid)
      else $error("telegram in no-function mode");
   AST_UP: assert property ($past(mode_q) == 2'h1 && mode_q == 2'h1 && tg.valid |-> !tg.down)
      else $error("up mode sent down");
   AST_DOWN: assert property ($past(mode_q) == 2'h2 && mode_q == 2'h2 && tg.valid |-> tg.down)
      else $error("down mode sent up");
   AST_SLS_RISE: assert property ($rose(btn) && mode_q != 2'h0 && !ls_q |-> ##[2:6] (tg.valid && !tg.move))
      else $error("no STEP after press");
   AST_LS_RISE: assert property ($rose(btn) && mode_q != 2'h0 && ls_q |-> ##[2:6] (tg.valid && tg.move))
      else $error("no MOVE after press");
   AST_TGL_MOVE: assert property (mode_q == 2'h3 && tg.valid && tg.move |-> tg.down != mv_dn)
      else $error("toggle MOVE not inverted");
   AST_TGL_STEP: assert property (mode_q == 2'h3 && tg.valid && !tg.move |-> tg.down == !mv_dn)
      else $error("toggle STEP direction wrong");
   AST_CFG_RD: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[4] == $past(ls_q))
      else $error("concept readback wrong");
   cover property ($rose(btn) && ls_q);
   cover property (tg.valid && tg.move && mode_q == 2'h3);
   cover property ($rose(btn) && mode_q == 2'h0);
endmodule // bps_sequencer_asserts
bind bps_sequencer bps_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES)) bps_sequencer_asserts_i (.ref_clk(ref_clk),
   .rst(rst), .btn(btn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .tg(tg));

// ==== bench/bps_tg_sink.sv ====
// telegram transmitter model: counts telegrams handed over
`timescale 1ns/100ps
module bps_tg_sink (
   input wire logic             ref_clk,
   input wire logic             rst,
   input wire bps_pkg::bps_tg_s tg,
   output logic [15:0]          count
);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) count <= 16'h0;
      else if (tg.valid) count <= count + 16'h1;
   end
endmodule // bps_tg_sink

// ==== bench/blind_pushbutton_sequencer_test.sv ====
// testbench for the blind push-button sequencer
`timescale 1ns/100ps
module blind_pushbutton_sequencer_test;
   logic             ref_clk;
   logic             rst;
   logic             btn;
   logic             reg_wr;
   logic             reg_rd;
   logic [7:0]       reg_addr;
   logic [31:0]      reg_wdata;
   logic [31:0]      reg_rdata;
   bps_pkg::bps_tg_s tg;
   logic [15:0]      tg_count;
   logic [1:0]       expq[$];
   int               err_total;
   int               samples_checked;
   bps_sequencer #(.TICK_CYCLES(10)) bps_sequencer_i (.ref_clk(ref_clk), .rst(rst), .btn(btn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tg(tg));
   bps_tg_sink bps_tg_sink_i (.ref_clk(ref_clk), .rst(rst), .tg(tg), .count(tg_count));
   task automatic fail(input string m);
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) fail("mismatch");
   endtask
   task automatic cmp_tg(input logic mv, input logic dn, input logic [1:0] e);
      samples_checked++;
      if ({mv, dn} !== e) fail("telegram kind or direction");
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      cmp(reg_rdata, e);
   endtask
   task automatic press(input int hold);
      @(posedge ref_clk);
      btn <= 1'b1;
      repeat (hold) @(posedge ref_clk);
      btn <= 1'b0;
      repeat (20) @(posedge ref_clk);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // telegram watcher: {move, down} against oldest note
   always @(posedge ref_clk) begin
      if (tg.valid === 1'b1) begin
         if (expq.size() == 0) fail("unexpected telegram");
         else cmp_tg(tg.move, tg.down, expq.pop_front());
      end
   end
   initial begin
      #100us;
      fail("timeout");
      end_sim;
   end
   initial begin
      rst = 1'b1;
      btn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      err_total = 0;
      samples_checked = 0;
      void'($urandom(32'h1ce4));
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      rd(bps_pkg::OFS_CFG, 32'h1);
      rd(bps_pkg::OFS_LTIME, 32'h400);
      rd(bps_pkg::OFS_STIME, 32'h1400);
      rd(8'h20, 32'h0);
      rd(bps_pkg::OFS_STATUS, 32'h9);
      // slat window set to the half-turn time of the slats
      wr(bps_pkg::OFS_STIME, 32'h1400);
      // toggle, long-short: MOVE then STEP each
      wr(bps_pkg::OFS_CFG, 32'h13);
      expq = {expq, 2'b10, 2'b01, 2'b11, 2'b00};
      press(50);
      rd(bps_pkg::OFS_STATUS, 32'h1);
      press(50);
      // toggle, short steps keep direction
      wr(bps_pkg::OFS_CFG, 32'h3);
      expq = {expq, 2'b00, 2'b00};
      press(5 + $urandom % 25);
      press(5 + $urandom % 25);
      rd(bps_pkg::OFS_STATUS, 32'h9);
      // up: short, then long released in window
      wr(bps_pkg::OFS_CFG, 32'h1);
      expq = {expq, 2'b00, 2'b00, 2'b10, 2'b00};
      press(5 + $urandom % 25);
      press(120);
      // down, released after window
      wr(bps_pkg::OFS_CFG, 32'h2);
      expq = {expq, 2'b01, 2'b11};
      press(300);
      wr(bps_pkg::OFS_CFG, 32'h0);
      press(120);
      // up again: each new press starts its own timing
      wr(bps_pkg::OFS_CFG, 32'h1);
      expq = {expq, 2'b00, 2'b00, 2'b10, 2'b00};
      press(10);
      press(60);
      // longer base, factor clamped to 4
      wr(bps_pkg::OFS_LTIME, 32'h201);
      rd(bps_pkg::OFS_LTIME, 32'h401);
      wr(bps_pkg::OFS_CFG, 32'h1);
      expq = {expq, 2'b00};
      press(60);
      // slat base above range and factor below minimum both clamp
      wr(bps_pkg::OFS_STIME, 32'h0109);
      rd(bps_pkg::OFS_STIME, 32'h308);
      rd(bps_pkg::OFS_TGCNT, 32'h11);
      cmp({16'h0, tg_count}, 32'h11);
      cmp(expq.size(), 32'h0);
      end_sim;
   end
endmodule // blind_pushbutton_sequencer_test
